// >>> common/anps_cfg.svh
// Constants for the negotiation next-page and result status register bank
`ifndef ANPS_CFG_SVH
`define ANPS_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define ANPS_IDX_TX_LOW        16'h0208
`define ANPS_IDX_TX_MID        16'h0209
`define ANPS_IDX_TX_HIGH       16'h020a
`define ANPS_IDX_PARTNER_LOW   16'h020b
`define ANPS_IDX_PARTNER_MID   16'h020c
`define ANPS_IDX_PARTNER_HIGH  16'h020d
`define ANPS_IDX_RESULT        16'h8001
`define ANPS_IDX_IRQ_STATUS    16'h8010
`define ANPS_IDX_IRQ_MASK      16'h8011

// Transmit low word fields
`define ANPS_TX_MORE_BIT       15
`define ANPS_TX_ACK_BIT        14
`define ANPS_TX_ENC_BIT        13
`define ANPS_TX_ACK2_BIT       12
`define ANPS_TX_TOGGLE_BIT     11
`define ANPS_TX_CODE_MSB       10

// Result status fields
`define ANPS_RES_PAGE_RX_BIT   8
`define ANPS_RES_INCOMPAT_BIT  7
`define ANPS_RES_MS_LSB        5
`define ANPS_RES_TECH_LSB      1
`define ANPS_RES_DONE_BIT      0

// Interrupt status and mask bits
`define ANPS_IRQ_PAGE_RX_BIT   0
`define ANPS_IRQ_DONE_BIT      1
`define ANPS_IRQ_INCOMPAT_BIT  2

// Reset values
`define ANPS_RST_TX_LOW        16'h2001
`define ANPS_RST_TX_MID        16'h0000
`define ANPS_RST_TX_HIGH       16'h0000
`define ANPS_RST_ZERO          16'h0000
`define ANPS_RST_IRQ_MASK      3'h0

// Codes of the transmit code field for a message page
`define ANPS_CODE_NULL         11'h001
`define ANPS_CODE_TAGGED       11'h005
`define ANPS_CODE_DEVICE_TAG   11'h006

`endif

// >>> common/anps_pkg.sv
// Types shared by the negotiation next-page and result status register bank
package anps_pkg;

   // Outcome of master/slave resolution
   typedef enum logic [1:0] {
      ANPS_MS_NOT_RUN = 2'h0,
      ANPS_MS_FAULT   = 2'h1,
      ANPS_MS_SLAVE   = 2'h2,
      ANPS_MS_MASTER  = 2'h3
   } anps_ms_t;

   // Highest common technology codes; others are reserved
   typedef enum logic [3:0] {
      ANPS_TECH_NONE   = 4'h0,
      ANPS_TECH_T1L    = 4'h1
   } anps_tech_t;

   // Three words of one next page
   typedef struct packed {
      logic [15:0] high;
      logic [15:0] mid;
      logic [15:0] low;
   } anps_page_t;

   // Result of the arbitration machine as it is seen live
   typedef struct packed {
      logic        incompatible;
      logic [1:0]  ms_outcome;
      logic [3:0]  tech;
      logic        done;
   } anps_result_t;

   // Interrupt events, one bit each
   typedef struct packed {
      logic incompatible;
      logic done;
      logic page_rx;
   } anps_irq_t;

   // Whole state of the register bank
   typedef struct packed {
      anps_page_t   tx_page;
      logic         tx_loaded;
      logic [15:0]  partner_mid_held;
      logic [15:0]  partner_high_held;
      logic         page_rx_latched;
      anps_irq_t    irq_status;
      anps_irq_t    irq_mask;
      logic         irq;
      logic         done_seen;
      logic         incompat_seen;
      logic         ack;
      logic [15:0]  rdata;
   } anps_state_t;

endpackage

// >>> rtl/anps_regs.sv
// Negotiation next-page and result status register bank on a classic Wishbone slave
// Notes on behaviour
// - Low transmit word bit 13 selects unformatted (0) or message (1); read/write, resets to 1.
// - Low transmit word bit 12 is read/write second acknowledge; resets to 0.
// - Low transmit word bit 11 toggle always reads 0; arbitration drives it.
// - Low transmit word bits 10:0 hold the code; resets to 1 (null message).
// - Power-up or negotiation reset restores transmit words; middle and high become zero.
// - Middle and high transmit words are 16-bit read/write at 0x0209 and 0x020a.
// - Reading partner low word at 0x020b captures partner middle and high words.
// - Reads at 0x020c and 0x020d return the copies captured by the last low read.
// - Partner low word is read-only, resets to zero, carries partner page fields.
// - Result bit 8 latches a received partner page request, cleared by reading.
// - Result bit 7 shows an incompatible link from priority resolution; read-only.
// - Result bits 6:5 give master/slave outcome: not run, fault, slave, master.
// - Result bits 4:1 give the common technology: 0 not run, 1 long-reach.
// - Result bit 0 shows negotiation transmission done and link coming or come up.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

`include "anps_cfg.svh"

module anps_regs
   import anps_pkg::*;
#(
   parameter int ADR_W = 18
)(
   input  wire logic              CLK_IN,
   input  wire logic              RESET_N_IN,
   // Classic Wishbone slave, 32-bit data, registers in the low 16 bits
   input  wire logic              WB_CYC_IN,
   input  wire logic              WB_STB_IN,
   input  wire logic              WB_WE_IN,
   input  wire logic [ADR_W-1:0]  WB_ADR_IN,
   input  wire logic [3:0]        WB_SEL_IN,
   input  wire logic [31:0]       WB_DAT_IN,
   output logic      [31:0]       WB_DAT_OUT,
   output logic                   WB_ACK_OUT,
   // Live partner page and result from the arbitration machine
   input  wire anps_page_t        PARTNER_PAGE_IN,
   input  wire logic              PARTNER_PAGE_RX_IN,
   input  wire anps_result_t      RESULT_IN,
   input  wire logic              NEG_RESET_IN,
   // Page handed to the arbitration machine
   output anps_page_t             TX_PAGE_OUT,
   output logic                   TX_PAGE_LOADED_OUT,
   output logic                   IRQ_OUT
);

   anps_state_t state;
   anps_state_t next_state;

   // Merges the two low byte lanes of a write into a 16-bit register
   function automatic logic [15:0] merge_lanes(input logic [15:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  sel);
      logic [15:0] res;
      res = old_val;
      if (sel[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (sel[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   // Compares the word index of the bus address with a register index
   function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
      return (adr[ADR_W-1:2] == idx);
   endfunction

   // Builds the readable image of the low transmit word
   function automatic logic [15:0] tx_low_view(input logic [15:0] stored);
      logic [15:0] v;
      v                        = stored;
      v[`ANPS_TX_ACK_BIT]      = 1'b0;
      v[`ANPS_TX_TOGGLE_BIT]   = 1'b0;
      return v;
   endfunction

   logic        access;
   logic        wr;
   logic        rd;
   logic [15:0] result_word;
   logic [15:0] tx_low_wr;
   anps_irq_t   irq_events;
   anps_irq_t   irq_clear;

   // A request is served on the first edge it is seen; ack follows one cycle later
   assign access = WB_CYC_IN & WB_STB_IN & ~state.ack;
   assign wr     = access & WB_WE_IN;
   assign rd     = access & ~WB_WE_IN;

   // Live image of the result status register
   always_comb begin
      result_word                                               = `ANPS_RST_ZERO;
      result_word[`ANPS_RES_PAGE_RX_BIT]                        = state.page_rx_latched;
      result_word[`ANPS_RES_INCOMPAT_BIT]                       = RESULT_IN.incompatible;
      result_word[`ANPS_RES_MS_LSB+1:`ANPS_RES_MS_LSB]          = RESULT_IN.ms_outcome;
      result_word[`ANPS_RES_TECH_LSB+3:`ANPS_RES_TECH_LSB]      = RESULT_IN.tech;
      result_word[`ANPS_RES_DONE_BIT]                           = RESULT_IN.done;
   end

   // Interrupt events; done and incompatible count on their rising edges only
   always_comb begin
      irq_events.page_rx      = PARTNER_PAGE_RX_IN;
      irq_events.done         = RESULT_IN.done & ~state.done_seen;
      irq_events.incompatible = RESULT_IN.incompatible & ~state.incompat_seen;
   end

   // Write-one-to-clear of the interrupt status
   always_comb begin
      irq_clear = '0;
      if (wr && hit(WB_ADR_IN, `ANPS_IDX_IRQ_STATUS) && WB_SEL_IN[0]) begin
         irq_clear = WB_DAT_IN[2:0];
      end
   end

   // Low transmit word as a write would leave it; ack and toggle bits are not stored
   always_comb begin
      tx_low_wr                        = merge_lanes(state.tx_page.low, WB_DAT_IN, WB_SEL_IN);
      tx_low_wr[`ANPS_TX_ACK_BIT]      = 1'b0;
      tx_low_wr[`ANPS_TX_TOGGLE_BIT]   = 1'b0;
   end

   // Next state of the whole bank
   always_comb begin
      next_state           = state;
      next_state.ack       = access;
      next_state.tx_loaded = 1'b0;

      // Register writes
      if (wr) begin
         if (hit(WB_ADR_IN, `ANPS_IDX_TX_LOW)) begin
            next_state.tx_page.low = tx_low_wr;
            // Low word goes last, so its write marks the page as complete
            next_state.tx_loaded   = 1'b1;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_TX_MID)) begin
            next_state.tx_page.mid = merge_lanes(state.tx_page.mid, WB_DAT_IN, WB_SEL_IN);
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_TX_HIGH)) begin
            next_state.tx_page.high = merge_lanes(state.tx_page.high, WB_DAT_IN, WB_SEL_IN);
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_IRQ_MASK) && WB_SEL_IN[0]) begin
            next_state.irq_mask = WB_DAT_IN[2:0];
         end
      end

      // Read data; unmapped words read as zero
      if (rd) begin
         next_state.rdata = `ANPS_RST_ZERO;
         if (hit(WB_ADR_IN, `ANPS_IDX_TX_LOW)) begin
            next_state.rdata = tx_low_view(state.tx_page.low);
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_TX_MID)) begin
            next_state.rdata = state.tx_page.mid;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_TX_HIGH)) begin
            next_state.rdata = state.tx_page.high;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_PARTNER_LOW)) begin
            next_state.rdata             = PARTNER_PAGE_IN.low;
            // Capture the upper words in the same edge so the three stay coherent
            next_state.partner_mid_held  = PARTNER_PAGE_IN.mid;
            next_state.partner_high_held = PARTNER_PAGE_IN.high;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_PARTNER_MID)) begin
            next_state.rdata = state.partner_mid_held;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_PARTNER_HIGH)) begin
            next_state.rdata = state.partner_high_held;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_RESULT)) begin
            next_state.rdata = result_word;
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_IRQ_STATUS)) begin
            next_state.rdata = {13'h0, state.irq_status};
         end
         if (hit(WB_ADR_IN, `ANPS_IDX_IRQ_MASK)) begin
            next_state.rdata = {13'h0, state.irq_mask};
         end
      end

      // Latched page request: a read clears it, but an event in the same cycle wins
      if (rd && hit(WB_ADR_IN, `ANPS_IDX_RESULT)) begin
         next_state.page_rx_latched = PARTNER_PAGE_RX_IN;
      end else if (PARTNER_PAGE_RX_IN) begin
         next_state.page_rx_latched = 1'b1;
      end

      // Sticky interrupt status; set beats a simultaneous clear
      next_state.irq_status    = (state.irq_status & ~irq_clear) | irq_events;
      next_state.done_seen     = RESULT_IN.done;
      next_state.incompat_seen = RESULT_IN.incompatible;
      next_state.irq           = |(next_state.irq_status & next_state.irq_mask);

      // Negotiation reset restores the default null message page and drops held copies
      if (NEG_RESET_IN) begin
         next_state.tx_page.low       = `ANPS_RST_TX_LOW;
         next_state.tx_page.mid       = `ANPS_RST_TX_MID;
         next_state.tx_page.high      = `ANPS_RST_TX_HIGH;
         next_state.tx_loaded         = 1'b0;
         next_state.partner_mid_held  = `ANPS_RST_ZERO;
         next_state.partner_high_held = `ANPS_RST_ZERO;
         next_state.page_rx_latched   = 1'b0;
      end
   end

   // State register; power-up reset gives the documented defaults
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state                   <= '0;
         state.tx_page.low       <= `ANPS_RST_TX_LOW;
         state.tx_page.mid       <= `ANPS_RST_TX_MID;
         state.tx_page.high      <= `ANPS_RST_TX_HIGH;
         state.irq_mask          <= `ANPS_RST_IRQ_MASK;
      end else begin
         state <= next_state;
      end
   end

   // Outputs come straight from the state flops
   assign WB_DAT_OUT         = {16'h0000, state.rdata};
   assign WB_ACK_OUT         = state.ack;
   assign TX_PAGE_OUT        = state.tx_page;
   assign TX_PAGE_LOADED_OUT = state.tx_loaded;
   assign IRQ_OUT            = state.irq;

endmodule // anps_regs

// >>> testbench/anps_regs_props.sv
// Checker of bus timing and register effects at the register bank ports
`timescale 1ns/1ps
module anps_regs_chk
   import anps_pkg::*;
#(
   parameter int ADR_W = 18
)(
   input wire logic             CLK_IN,
   input wire logic             RESET_N_IN,
   input wire logic             WB_CYC_IN,
   input wire logic             WB_STB_IN,
   input wire logic             WB_WE_IN,
   input wire logic [ADR_W-1:0] WB_ADR_IN,
   input wire logic [3:0]       WB_SEL_IN,
   input wire logic [31:0]      WB_DAT_IN,
   input wire logic [31:0]      WB_DAT_OUT,
   input wire logic             WB_ACK_OUT,
   input wire anps_page_t       PARTNER_PAGE_IN,
   input wire anps_result_t     RESULT_IN,
   input wire logic             NEG_RESET_IN,
   input wire anps_page_t       TX_PAGE_OUT,
   input wire logic             TX_PAGE_LOADED_OUT
);
   // Requests taken at this edge, split by target
   logic take;
   logic wr_low;
   logic wr_mid;
   logic rd_plow;
   logic rd_res;
   assign take    = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   assign wr_low  = take & WB_WE_IN & (WB_ADR_IN == ADR_W'(18'h820)) & (WB_SEL_IN[1:0] == 2'h3) & ~NEG_RESET_IN;
   assign wr_mid  = take & WB_WE_IN & (WB_ADR_IN == ADR_W'(18'h824)) & (WB_SEL_IN[1:0] == 2'h3) & ~NEG_RESET_IN;
   assign rd_plow = take & ~WB_WE_IN & (WB_ADR_IN == ADR_W'(18'h82c));
   assign rd_res  = take & ~WB_WE_IN & (WB_ADR_IN == ADR_W'(18'h20004));

   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   chk_ack_answer: assert property (take |=> WB_ACK_OUT)
      else $error("request not acknowledged");
   chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("acknowledge longer than one cycle");
   chk_low_write: assert property (wr_low |=> TX_PAGE_OUT.low == ($past(WB_DAT_IN[15:0]) & 16'hb7ff))
      else $error("low transmit word not stored");
   chk_toggle_zero: assert property (TX_PAGE_OUT.low[11] == 1'b0)
      else $error("toggle bit not zero");
   chk_mid_write: assert property (wr_mid |=> TX_PAGE_OUT.mid == $past(WB_DAT_IN[15:0]))
      else $error("middle transmit word not stored");
   chk_neg_default: assert property (NEG_RESET_IN |=> TX_PAGE_OUT == {16'h0000, 16'h0000, 16'h2001})
      else $error("transmit words not restored");
   chk_partner_live: assert property (rd_plow |=> WB_DAT_OUT[15:0] == $past(PARTNER_PAGE_IN.low))
      else $error("partner low word not live");
   chk_result_live: assert property (rd_res |=> WB_DAT_OUT[7:0] == $past(RESULT_IN))
      else $error("result bits not live");
   chk_page_loaded: assert property (wr_low |=> TX_PAGE_LOADED_OUT)
      else $error("loaded pulse missing");
endmodule // anps_regs_chk

// >>> testbench/anps_partner_model.sv
// Model of the arbitration side that feeds partner pages, results and resets
`timescale 1ns/1ps
module anps_partner_model
   import anps_pkg::*;
(
   input  wire logic    clk_in,
   output anps_page_t   page_out,
   output logic         rx_out,
   output anps_result_t result_out,
   output logic         neg_out
);
   // Quiet until the bench commands a change
   initial begin
      page_out = '0;
      rx_out = 1'b0;
      result_out = '0;
      neg_out = 1'b0;
   end
   // Changes land just after an edge, as from registers
   task automatic set_page(input anps_page_t p);
      @(posedge clk_in);
      page_out <= p;
   endtask
   task automatic set_result(input anps_result_t r);
      @(posedge clk_in);
      result_out <= r;
   endtask
   // Level of the page event, for a read that meets a lasting event
   task automatic hold_rx(input logic v);
      @(posedge clk_in);
      rx_out <= v;
   endtask
   // One-cycle event; a long level would hide the clear on read
   task automatic pulse(input logic neg);
      @(posedge clk_in);
      rx_out <= ~neg;
      neg_out <= neg;
      @(posedge clk_in);
      rx_out <= 1'b0;
      neg_out <= 1'b0;
   endtask
endmodule // anps_partner_model

// >>> testbench/anps_regs_bench.sv
// Register-level tests of the negotiation next-page and result bank
`timescale 1ns/1ps
module anps_regs_bench;
   import anps_pkg::*;
   logic         clk;
   logic         rst_n;
   logic         req;
   logic         we;
   logic [17:0]  adr;
   logic [15:0]  wd;
   logic [31:0]  rdat;
   logic         ack;
   logic         irq;
   anps_page_t   txp;
   anps_page_t   pp;
   anps_result_t res;
   logic         prx;
   logic         neg;
   int           mismatches;
   int           n_checks;
   logic [15:0]  codes [3] = '{16'h2001, 16'h2005, 16'h2006};

   anps_regs anps_regs_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(req), .WB_STB_IN(req), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN({16'h0000, wd}), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .PARTNER_PAGE_IN(pp), .PARTNER_PAGE_RX_IN(prx), .RESULT_IN(res), .NEG_RESET_IN(neg),
      .TX_PAGE_OUT(txp), .TX_PAGE_LOADED_OUT(), .IRQ_OUT(irq));
   anps_partner_model partner_inst (.clk_in(clk), .page_out(pp), .rx_out(prx), .result_out(res), .neg_out(neg));

   // 50 ns period
   always #25 clk = ~clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [17:0] a, input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat[15:0];
      req <= 1'b0;
      if (n >= 50) chk("ack wait", 48'h1, 48'h0);
   endtask
   task automatic wr(input logic [17:0] a, input logic [15:0] d);
      logic [15:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [17:0] a, input logic [15:0] e, input string nm);
      logic [15:0] r;
      wb(1'b0, a, 16'h0000, r);
      chk(nm, {32'h0, e}, {32'h0, r});
   endtask

   // Watchdog far beyond the hundred or so cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      req = 1'b0;
      we = 1'b0;
      adr = '0;
      wd = '0;
      mismatches = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(18'h820, 16'h2001, "tx low reset");
      rd(18'h828, 16'h0000, "tx high reset");
      rd(18'h82c, 16'h0000, "partner low reset");
      wr(18'h824, 16'ha5c3);
      wr(18'h828, 16'h1234);
      wr(18'h820, 16'h5fff);
      rd(18'h824, 16'ha5c3, "tx mid");
      rd(18'h820, 16'h17ff, "tx low");
      chk("tx page", {16'h1234, 16'ha5c3, 16'h17ff}, txp);
      for (int i = 0; i < 3; i++) begin
         wr(18'h820, codes[i]);
         rd(18'h820, codes[i], "message code");
      end
      partner_inst.set_page({16'h1111, 16'h2222, 16'h8abc});
      rd(18'h82c, 16'h8abc, "partner low");
      partner_inst.set_page({16'h4444, 16'h3333, 16'h0abc});
      rd(18'h830, 16'h2222, "partner mid held");
      rd(18'h834, 16'h1111, "partner high held");
      rd(18'h82c, 16'h0abc, "partner low live");
      rd(18'h834, 16'h4444, "partner high new");
      for (int i = 0; i < 4; i++) begin
         partner_inst.set_result({i[0], i[1:0], 4'h1, i[1]});
         rd(18'h20004, {8'h00, i[0], i[1:0], 4'h1, i[1]}, "result");
      end
      partner_inst.set_result('0);
      partner_inst.pulse(1'b0);
      rd(18'h20004, 16'h0100, "page rx latched");
      rd(18'h20004, 16'h0000, "page rx cleared");
      partner_inst.hold_rx(1'b1);
      rd(18'h20004, 16'h0100, "page rx held");
      partner_inst.hold_rx(1'b0);
      rd(18'h20004, 16'h0100, "page rx persisted");
      rd(18'h20004, 16'h0000, "page rx released");
      chk("irq masked", 48'h0, {47'h0, irq});
      wr(18'h20044, 16'h0001);
      chk("irq raised", 48'h1, {47'h0, irq});
      rd(18'h20040, 16'h0007, "irq status");
      wr(18'h20040, 16'h0001);
      chk("irq cleared", 48'h0, {47'h0, irq});
      rd(18'h30000, 16'h0000, "unmapped");
      partner_inst.pulse(1'b1);
      rd(18'h820, 16'h2001, "tx low neg reset");
      rd(18'h824, 16'h0000, "tx mid neg reset");
      report_and_stop();
   end
endmodule // anps_regs_bench

bind anps_regs anps_regs_chk #(.ADR_W(ADR_W)) chk_inst (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
   .PARTNER_PAGE_IN(PARTNER_PAGE_IN), .RESULT_IN(RESULT_IN), .NEG_RESET_IN(NEG_RESET_IN),
   .TX_PAGE_OUT(TX_PAGE_OUT), .TX_PAGE_LOADED_OUT(TX_PAGE_LOADED_OUT));
